/* File: bench/sccm_ext_osc_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sccm_ext_osc_model (
  // clock and control
  input  wire logic       clock_i,
  input  wire logic       run_i,
  input  wire logic [3:0] half_i,
  input  wire logic [2:0] mode_i,
  // oscillator pin
  output logic            pin_o
);
  logic [3:0] cnt;
  initial begin
    cnt   = 4'h0;
    pin_o = 1'b0;
  end
  // stopped or off circuit leaves the pin idle low, no stray edges
  always @(posedge clock_i) begin
    if (!run_i || mode_i[2:1] == 2'h0) begin
      cnt   <= 4'h0;
      pin_o <= 1'b0;
    end else if (cnt + 4'h1 >= half_i) begin
      cnt   <= 4'h0;
      pin_o <= !pin_o;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule
`default_nettype wire

/* File: bench/system_clock_source_control_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fail_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module system_clock_source_control_tb
  import sccm_pkg::*;
;
  localparam int MCD = 50;
  localparam int XE  = 8;
  logic          clock_i, reset_n_i, run, pin, osc_en, sys_en, ext_en, mcr, rd_d;
  logic [3:0]    half;
  logic [2:0]    mode, freq;
  logic [7:0]    rdata, trim_o, exp_v, t;
  sccm_sfr_req_t sfr;
  logic [7:0]    expq[$];
  int            fail_count, compares, idle, n_sys, n_ext, n_mcr, k;

  sccm_clock_control #(.MCD_CYCLES(MCD), .XTAL_EDGES(XE)) dut (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .sfr_i(sfr), .sfr_rdata_o(rdata),
    .crystal_pin_one_i(pin), .external_mode_field_o(mode), .external_freq_control_o(freq),
    .internal_osc_enable_o(osc_en), .internal_osc_trim_o(trim_o), .sysclk_en_o(sys_en),
    .ext_clk_en_o(ext_en), .missing_clock_reset_o(mcr));
  sccm_ext_osc_model xosc (.clock_i(clock_i), .run_i(run), .half_i(half), .mode_i(mode),
    .pin_o(pin));

  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end

  // read data lands one cycle after the strobe; oldest note is the match
  always @(posedge clock_i) begin
    if (rd_d) begin
      exp_v = (expq.size() > 0) ? expq.pop_front() : 8'hxx;
      `CHK(rdata, exp_v)
    end
    rd_d <= sfr.rd;
    idle = sys_en ? 0 : idle + 1;
    n_sys += sys_en;
    n_ext += ext_en;
    n_mcr += mcr;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    sfr <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge clock_i);
    sfr <= '0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock_i);
    sfr <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    expq.push_back(e);
    @(posedge clock_i);
    sfr <= '0;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  // window counts of clock enables and missing clock resets, cleared off the edge
  task automatic count(input int n);
    @(posedge clock_i);
    #1;
    n_sys = 0;
    n_ext = 0;
    n_mcr = 0;
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic near(input int got, input int e, input int tol);
    `CHK(got >= e - tol && got <= e + tol, 1'b1)
  endtask
  task results;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    reset_n_i = 1'b0;
    sfr = '0;
    run = 1'b1;
    half = 4'h4;
    rd_d = 1'b0;
    idle = 0;
    void'($urandom(83));
    cyc(10);
    reset_n_i <= 1'b1;
    rd(INTERNAL_OSC_CONTROL_ADDR, INTERNAL_OSC_CONTROL_RESET);
    rd(INTERNAL_OSC_TRIM_ADDR, TRIM_RESET_DEFAULT);
    rd(EXTERNAL_OSC_CONTROL_ADDR, 8'h00);
    rd(SYSCLK_SOURCE_SELECT_ADDR, 8'h00);
    rd(8'h55, 8'h00);
    // trim 0x80 ticks every second cycle, so 128 internal ticks per 256
    for (int d = 0; d < 4; d++) begin
      wr(INTERNAL_OSC_CONTROL_ADDR, {6'h20, d[1:0]});
      cyc(40);
      count(256);
      near(n_sys, 16 << d, 1);
    end
    wr(INTERNAL_OSC_CONTROL_ADDR, 8'h03);
    `CHK(osc_en, 1'b0)
    rd(INTERNAL_OSC_CONTROL_ADDR, 8'h03);
    count(64);
    `CHK(n_sys, 0)
    wr(INTERNAL_OSC_CONTROL_ADDR, 8'h83);
    rd(INTERNAL_OSC_CONTROL_ADDR, 8'h83);
    cyc(12);
    rd(INTERNAL_OSC_CONTROL_ADDR, 8'hc3);
    `CHK(osc_en, 1'b1)
    // trim kept below the reset trim so the frequency stays in range
    t = 8'h40 | 8'($urandom % 64);
    wr(INTERNAL_OSC_TRIM_ADDR, t);
    `CHK(trim_o, t)
    rd(INTERNAL_OSC_TRIM_ADDR, t);
    wr(INTERNAL_OSC_TRIM_ADDR, 8'h80);
    for (int m = 0; m < 8; m++) begin
      t = 8'($urandom % 8);
      wr(EXTERNAL_OSC_CONTROL_ADDR, {1'b0, m[2:0], 1'b1, t[2:0]});
      `CHK({mode, freq}, {m[2:0], t[2:0]})
      rd(EXTERNAL_OSC_CONTROL_ADDR, {1'b0, m[2:0], 1'b0, t[2:0]});
    end
    wr(EXTERNAL_OSC_CONTROL_ADDR, 8'h67);
    cyc(20);
    rd(EXTERNAL_OSC_CONTROL_ADDR, 8'h67);
    cyc(100);
    rd(EXTERNAL_OSC_CONTROL_ADDR, 8'he7);
    count(256);
    near(n_ext, 32, 1);
    wr(SYSCLK_SOURCE_SELECT_ADDR, 8'h01);
    cyc(20);
    count(256);
    near(n_sys, 32, 1);
    rd(SYSCLK_SOURCE_SELECT_ADDR, 8'h01);
    wr(RESET_SOURCE_REGISTER_ADDR, 8'h04);
    rd(RESET_SOURCE_REGISTER_ADDR, 8'h04);
    run <= 1'b0;
    for (k = 0; k < 100 && mcr !== 1'b1; k++) @(posedge clock_i);
    `CHK(mcr, 1'b1)
    if (mcr !== 1'b1) results;
    near(idle, MCD, 2);
    wr(RESET_SOURCE_REGISTER_ADDR, 8'h00);
    count(120);
    `CHK(n_mcr, 0)
    // a stopped source never hands over, so only a reset recovers
    reset_n_i <= 1'b0;
    cyc(2);
    reset_n_i <= 1'b1;
    run <= 1'b1;
    rd(SYSCLK_SOURCE_SELECT_ADDR, 8'h00);
    count(256);
    near(n_sys, 16, 1);
    cyc(2);
    results;
  end
endmodule
`default_nettype wire

/* File: core/sccm_clock_control.sv */
// Behaviour
// - reset runs system clock from internal oscillator
// - divider field picks divide 8/4/2/1
// - enable bit starts and stops internal oscillator
// - ready flag set only while oscillator settled
// - select bit picks internal or external source
// - external clock stays available for timers
// - enable and select in one write; the select bit is at SYSCLK_SOURCE_SELECT_ADDR, a separate write
// - crystal valid set once crystal settled
// - mode field selects external circuit type
// - frequency field sets drive range or K
// - external control bit 3 reads zero
// - trim register sets period, factory reset value
// - missing clock timeout starts a reset
// - missing clock detector gated by enable bit
`timescale 1ns/1ps
`default_nettype none
module sccm_clock_control
  import sccm_pkg::*;
#(
  parameter logic [7:0] TRIM_RESET  = TRIM_RESET_DEFAULT,
  parameter int         MCD_CYCLES  = MCD_TIMEOUT_CYCLES,
  parameter int         XTAL_EDGES  = XTAL_SETTLE_EDGES
) (
  // clock and reset
  input  wire logic          clock_i,
  input  wire logic          reset_n_i,
  // special function register port
  input  wire sccm_sfr_req_t sfr_i,
  output logic [7:0]         sfr_rdata_o,
  // external oscillator pin side
  input  wire logic          crystal_pin_one_i,
  output logic [2:0]         external_mode_field_o,
  output logic [2:0]         external_freq_control_o,
  // internal oscillator analog side
  output logic               internal_osc_enable_o,
  output logic [7:0]         internal_osc_trim_o,
  // clock enables and reset request
  output logic               sysclk_en_o,
  output logic               ext_clk_en_o,
  output logic               missing_clock_reset_o
);

  localparam int MW = $clog2(MCD_CYCLES + 1);
  localparam int XW = $clog2(XTAL_EDGES + 1);
  localparam int IW = $clog2(IOSC_START_CYCLES + 1);

  // register state
  logic       ien, next_ien;
  logic [1:0] divsel, next_divsel;
  logic [7:0] trim, next_trim;
  logic       srcsel, next_srcsel;
  logic [2:0] xmode, next_xmode;
  logic [2:0] xfreq, next_xfreq;
  logic       mcd_en, next_mcd_en;
  logic [7:0] rdata, next_rdata;

  logic wr_ctl, wr_trim;
  logic ready;
  logic xvalid;

  always_comb begin
    wr_ctl      = sfr_i.wr && sfr_i.addr == INTERNAL_OSC_CONTROL_ADDR;
    wr_trim     = sfr_i.wr && sfr_i.addr == INTERNAL_OSC_TRIM_ADDR;
    next_ien    = ien;
    next_divsel = divsel;
    next_trim   = trim;
    next_srcsel = srcsel;
    next_xmode  = xmode;
    next_xfreq  = xfreq;
    next_mcd_en = mcd_en;
    next_rdata  = rdata;
    if (wr_ctl) begin
      next_ien  = sfr_i.wdata[IOSC_ENABLE_BIT];
      next_divsel = sfr_i.wdata[DIV_SELECT_LSB +: 2];
    end
    if (wr_trim) begin
      next_trim = sfr_i.wdata;
    end
    if (sfr_i.wr && sfr_i.addr == SYSCLK_SOURCE_SELECT_ADDR) begin
      next_srcsel = sfr_i.wdata[SOURCE_SELECT_BIT];
    end
    if (sfr_i.wr && sfr_i.addr == EXTERNAL_OSC_CONTROL_ADDR) begin
      next_xmode = sfr_i.wdata[XMODE_LSB +: 3];
      next_xfreq = sfr_i.wdata[XFREQ_LSB +: 3];
    end
    if (sfr_i.wr && sfr_i.addr == RESET_SOURCE_REGISTER_ADDR) begin
      next_mcd_en = sfr_i.wdata[MCD_ENABLE_BIT];
    end
    if (sfr_i.rd) begin
      unique case (sfr_i.addr)
        INTERNAL_OSC_CONTROL_ADDR:  next_rdata = {ien, ready, 4'h0, divsel};
        INTERNAL_OSC_TRIM_ADDR:     next_rdata = trim;
        EXTERNAL_OSC_CONTROL_ADDR:  next_rdata = {xvalid, xmode, 1'b0, xfreq};
        SYSCLK_SOURCE_SELECT_ADDR:  next_rdata = {7'h00, srcsel};
        RESET_SOURCE_REGISTER_ADDR: next_rdata = {5'h00, mcd_en, 2'h0};
        default:                    next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ien    <= INTERNAL_OSC_CONTROL_RESET[IOSC_ENABLE_BIT];
      divsel <= INTERNAL_OSC_CONTROL_RESET[DIV_SELECT_LSB +: 2];
      trim   <= TRIM_RESET;
      srcsel <= 1'b0;
      xmode  <= EXTERNAL_OSC_CONTROL_RESET[XMODE_LSB +: 3];
      xfreq  <= EXTERNAL_OSC_CONTROL_RESET[XFREQ_LSB +: 3];
      mcd_en <= 1'b0;
      rdata  <= 8'h00;
    end else begin
      ien    <= next_ien;
      divsel <= next_divsel;
      trim   <= next_trim;
      srcsel <= next_srcsel;
      xmode  <= next_xmode;
      xfreq  <= next_xfreq;
      mcd_en <= next_mcd_en;
      rdata  <= next_rdata;
    end
  end

  // internal oscillator: trim is a phase step, so a larger trim is a faster oscillator
  logic [8:0]  acc, next_acc;
  logic [IW-1:0] icnt, next_icnt;
  logic        int_tick;
  logic [2:0]  div_cnt, next_div_cnt;
  logic [1:0]  div_act, next_div_act;
  logic [2:0]  div_mask;
  logic        div_tick;

  always_comb begin
    next_acc = ien ? {1'b0, acc[7:0]} + {1'b0, trim} : 9'h000;
    int_tick = ien && acc[8];
    // retrim restarts the settle window, so ready never covers a frequency step
    next_icnt = icnt;
    if (!ien || wr_trim) begin
      next_icnt = '0;
    end else if (icnt != IW'(IOSC_START_CYCLES)) begin
      next_icnt = icnt + 1'b1;
    end
    ready = ien && icnt == IW'(IOSC_START_CYCLES);
    unique case (div_act)
      DIV_BY8: div_mask = 3'h7;
      DIV_BY4: div_mask = 3'h3;
      DIV_BY2: div_mask = 3'h1;
      DIV_BY1: div_mask = 3'h0;
    endcase
    div_tick      = int_tick && div_cnt == div_mask;
    next_div_cnt  = div_cnt;
    next_div_act  = div_act;
    // new ratio taken only at a period boundary, never mid-phase
    if (!ien || div_tick) begin
      next_div_cnt  = 3'h0;
      next_div_act  = divsel;
    end else if (int_tick) begin
      next_div_cnt = div_cnt + 1'b1;
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      acc      <= 9'h000;
      icnt     <= IW'(IOSC_START_CYCLES);
      div_cnt  <= 3'h0;
      div_act  <= INTERNAL_OSC_CONTROL_RESET[DIV_SELECT_LSB +: 2];
    end else begin
      acc      <= next_acc;
      icnt     <= next_icnt;
      div_cnt  <= next_div_cnt;
      div_act  <= next_div_act;
    end
  end

  // external oscillator path
  logic          ext_prev, ext_half, next_ext_half;
  logic          ext_rise, ext_on, ext_halved, ext_tick;
  logic          xtal_mode;
  logic [XW-1:0] xcnt, next_xcnt;

  always_comb begin
    ext_rise      = crystal_pin_one_i && !ext_prev;
    ext_on        = xmode[2:1] != 2'h0;
    ext_halved    = xmode == XMODE_CMOS_HALF || xmode[2:1] == 2'h2 || xmode == XMODE_XTAL_HALF;
    xtal_mode     = xmode[2:1] == XMODE_XTAL[2:1];
    next_ext_half = ext_on ? ext_half ^ ext_rise : 1'b0;
    ext_tick      = ext_on && ext_rise && (!ext_halved || ext_half);
    next_xcnt     = '0;
    if (xtal_mode) begin
      next_xcnt = (ext_rise && xcnt != XW'(XTAL_EDGES)) ? xcnt + 1'b1 : xcnt;
    end
    xvalid = xtal_mode && xcnt == XW'(XTAL_EDGES);
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ext_prev <= 1'b0;
      ext_half <= 1'b0;
      xcnt     <= '0;
    end else begin
      ext_prev <= crystal_pin_one_i;
      ext_half <= next_ext_half;
      xcnt     <= next_xcnt;
    end
  end

  // source mux and missing clock detector
  logic          active_sel, next_active_sel;
  logic          sys_tick, old_tick;
  logic          sys_q, ext_q, mcd_q;
  logic          next_mcd;
  logic [MW-1:0] mcnt, next_mcnt;

  always_comb begin
    sys_tick = active_sel ? ext_tick : div_tick;
    old_tick = sys_tick;
    // a dead old source would stall the switch; software must not select one
    next_active_sel = (srcsel != active_sel && old_tick) ? srcsel : active_sel;
    next_mcd  = 1'b0;
    next_mcnt = '0;
    if (mcd_en && !sys_tick) begin
      if (mcnt == MW'(MCD_CYCLES - 1)) begin
        next_mcd = 1'b1;
      end else begin
        next_mcnt = mcnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      active_sel <= 1'b0;
      sys_q      <= 1'b0;
      ext_q      <= 1'b0;
      mcd_q      <= 1'b0;
      mcnt       <= '0;
    end else begin
      active_sel <= next_active_sel;
      sys_q      <= sys_tick;
      ext_q      <= ext_tick;
      mcd_q      <= next_mcd;
      mcnt       <= next_mcnt;
    end
  end

  assign sfr_rdata_o             = rdata;
  assign external_mode_field_o   = xmode;
  assign external_freq_control_o = xfreq;
  assign internal_osc_enable_o   = ien;
  assign internal_osc_trim_o     = trim;
  assign sysclk_en_o             = sys_q;
  assign ext_clk_en_o            = ext_q;
  assign missing_clock_reset_o   = mcd_q;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);

  reset_internal_sel_a: assert property ($rose(reset_n_i) |-> !active_sel)
    else $error("source not internal after reset");
  div1_every_tick_a: assert property (div_act == DIV_BY1 && int_tick |-> div_tick)
    else $error("divide by one dropped a tick");
  osc_stopped_a: assert property (!ien |-> ##1 !int_tick)
    else $error("internal oscillator ticks while disabled");
  ready_needs_en_a: assert property ($fell(ien) |-> !ready [*2])
    else $error("ready flag set with oscillator stopped");
  sysclk_source_a: assert property (!active_sel && !ien |-> ##1 !sysclk_en_o)
    else $error("system clock from wrong source");
  ext_available_a: assert property (ext_on && !ext_halved && ext_rise |-> ##1 ext_clk_en_o)
    else $error("external enable missing");
  single_write_a: assert property (wr_ctl && sfr_i.wdata[IOSC_ENABLE_BIT] |-> ##1 ien)
    else $error("enable not taken in one write");
  xvalid_mode_a: assert property (!xtal_mode |-> ##1 !xvalid)
    else $error("crystal valid outside crystal mode");
  ext_off_a: assert property (xmode[2:1] == 2'h0 |-> !ext_tick)
    else $error("external ticks while off");
  reserved_zero_a: assert property (sfr_i.rd && sfr_i.addr == EXTERNAL_OSC_CONTROL_ADDR
                                    |-> ##1 !sfr_rdata_o[3])
    else $error("reserved bit reads one");
  mcd_gated_a: assert property (missing_clock_reset_o |-> $past(mcd_en))
    else $error("missing clock reset while disabled");
  switch_on_tick_a: assert property ($changed(active_sel) |-> $past(old_tick))
    else $error("source switched mid-phase");

  switch_ext_c: cover property ($rose(active_sel));
  mcd_fire_c: cover property (missing_clock_reset_o);
  xvalid_c: cover property ($rose(xvalid));
  div8_tick_c: cover property (div_tick && div_act == DIV_BY8);

endmodule
`default_nettype wire

/* File: core/sccm_pkg.sv */
package sccm_pkg;

  // special function register map
  localparam logic [7:0] INTERNAL_OSC_CONTROL_ADDR  = 8'h8a;
  localparam logic [7:0] INTERNAL_OSC_TRIM_ADDR     = 8'h8b;
  localparam logic [7:0] EXTERNAL_OSC_CONTROL_ADDR  = 8'h8c;
  localparam logic [7:0] SYSCLK_SOURCE_SELECT_ADDR  = 8'h97;
  localparam logic [7:0] RESET_SOURCE_REGISTER_ADDR = 8'hef;

  // field positions
  localparam int IOSC_ENABLE_BIT   = 7;
  localparam int IOSC_READY_BIT    = 6;
  localparam int DIV_SELECT_LSB    = 0;
  localparam int SOURCE_SELECT_BIT = 0;
  localparam int XTAL_VALID_BIT    = 7;
  localparam int XMODE_LSB         = 4;
  localparam int XFREQ_LSB         = 0;
  localparam int MCD_ENABLE_BIT    = 2;

  // reset values
  localparam logic [7:0] INTERNAL_OSC_CONTROL_RESET = 8'hc0;
  localparam logic [7:0] EXTERNAL_OSC_CONTROL_RESET = 8'h00;
  localparam logic [7:0] TRIM_RESET_DEFAULT         = 8'h80; // arbitrary factory trim stand-in

  // divider select encodings
  localparam logic [1:0] DIV_BY8 = 2'h0;
  localparam logic [1:0] DIV_BY4 = 2'h1;
  localparam logic [1:0] DIV_BY2 = 2'h2;
  localparam logic [1:0] DIV_BY1 = 2'h3;

  // external mode encodings
  localparam logic [2:0] XMODE_CMOS      = 3'h2;
  localparam logic [2:0] XMODE_CMOS_HALF = 3'h3;
  localparam logic [2:0] XMODE_XTAL      = 3'h6;
  localparam logic [2:0] XMODE_XTAL_HALF = 3'h7;

  // timing
  localparam int CLK_PERIOD_NS      = 8;
  localparam int IOSC_START_NS      = 80;
  localparam int IOSC_START_CYCLES  = (IOSC_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MCD_TIMEOUT_US     = 200;
  localparam int MCD_TIMEOUT_CYCLES = MCD_TIMEOUT_US * 1000 / CLK_PERIOD_NS;
  localparam int XTAL_SETTLE_EDGES  = 1024;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } sccm_sfr_req_t;

endpackage
